//--- rtl/reset_ctrl_pkg.sv
package reset_ctrl_pkg;

  // Bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index
  localparam logic [15:0] CAUSE_IDX      = 16'h0FCC;
  localparam logic [15:0] PIN_CTRL_IDX   = 16'h0FDE;
  localparam logic [15:0] CODE_IDX       = 16'h0FDF;
  localparam logic [15:0] IRQ_STATUS_IDX = 16'h0FE0;
  localparam logic [15:0] IRQ_MASK_IDX   = 16'h0FE1;

  // Enable codes written to the enable code port
  localparam logic [7:0] KEY_EXT_DIS  = 8'hB2;
  localparam logic [7:0] KEY_AUX      = 8'hD4;
  localparam logic [7:0] KEY_FLAG_CLR = 8'h71;

  // Reset pin control and effective status field positions
  localparam int PIN_EXT_DIS_BIT = 0;
  localparam int PIN_AUX_A_BIT   = 1;
  localparam int PIN_AUX_B_BIT   = 2;

  // Reset cause register field positions
  localparam int CAUSE_WDT_BIT   = 0;
  localparam int CAUSE_CLK_BIT   = 1;
  localparam int CAUSE_LVD1_BIT  = 2;
  localparam int CAUSE_LVD2_BIT  = 3;
  localparam int CAUSE_TRIM_BIT  = 4;
  localparam int CAUSE_TSTAT_BIT = 5;
  localparam int CAUSE_FLASH_BIT = 6;
  localparam int CAUSE_FCLR_BIT  = 7;

  // Interrupt status extra event position
  localparam int IRQ_WARM_DONE_BIT = 7;

  // Reset values
  localparam logic [2:0] PIN_CTRL_RST  = 3'h0;
  localparam logic [6:0] CAUSE_RST     = 7'h00;
  localparam logic [7:0] IRQ_MASK_RST  = 8'h00;
  localparam logic [7:0] IRQ_STAT_RST  = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // Warm-up timing after reset release
  localparam int CLK_PERIOD_NS  = 100;
  localparam int WARMUP_TIME_NS = 400000;
  localparam int WARMUP_CYCLES  = (WARMUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WARMUP_CNT_W   = 12;

  // Warm-up sequencer states
  typedef enum logic [1:0] {
    WARM_HOLD  = 2'b00,
    WARM_COUNT = 2'b01,
    WARM_RUN   = 2'b10
  } warm_state_e;

  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
    reg_addr = {idx[13:0], 2'b00};
  endfunction

endpackage

//--- rtl/warmup_sequencer.sv
`timescale 1ns/100ps
`default_nettype none

module warmup_sequencer
  import reset_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Merged reset level
  input  wire logic reset_active,
  // Warm-up finished, fetch may start
  output logic      warm_done
);

  warm_state_e             state_reg;
  warm_state_e             state_next;
  logic [WARMUP_CNT_W-1:0] count_reg;
  logic                    last_count;

  assign last_count = (count_reg == WARMUP_CNT_W'(WARMUP_CYCLES - 1));

  // Any reset during warm-up sends it back to hold and restarts
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      WARM_HOLD:  if (!reset_active) state_next = WARM_COUNT;
      WARM_COUNT: if (reset_active) state_next = WARM_HOLD;
                  else if (last_count) state_next = WARM_RUN;
      WARM_RUN:   if (reset_active) state_next = WARM_HOLD;
      default:    state_next = WARM_HOLD;
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= WARM_HOLD;
    end else begin
      state_reg <= state_next;
    end
  end

  // Counter cleared whenever not counting
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (state_reg == WARM_COUNT && !reset_active) begin
      count_reg <= count_reg + 1'b1;
    end else begin
      count_reg <= '0;
    end
  end

  // Done flag registered
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      warm_done <= 1'b0;
    end else begin
      warm_done <= (state_next == WARM_RUN);
    end
  end

endmodule

`default_nettype wire

//--- rtl/reset_control.sv
// Function
// - Merge external input and seven internal sources into one system reset.
// - Pin control bit 0: zero honours external reset, one ignores it.
// - Effective disable copy cleared only by power-on reset.
// - Written pin control contents clear on every kind of reset.
// - Disable bit takes effect only after key B2 hits the code port.
// - Code port acts on B2, D4 and 71; other values ignored.
// - Status at code port address shows effective disable in bit 0.
// - Pin control bits 7 to 3 read zero.
// - Cause flags set by matching internal reset sources.
// - Cause bit 5 shows abnormal trimming data detected.
// - Cause flags cleared by power-on, external reset or keyed clear only.
// - Clear request plus key 71 zeros flags and drops request.
// - Cause bit 7 clear request reads back zero.
// - After release a warm-up count runs before CPU fetch.
// - Reset during warm-up restarts the count after the new release.
`timescale 1ns/100ps
`default_nettype none

module reset_control
  import reset_ctrl_pkg::*;
(
  // Clock and power-on domain reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Reset sources
  input  wire logic              ext_reset_n,
  input  wire logic              power_on_reset_req,
  input  wire logic              lvd1_reset_req,
  input  wire logic              lvd2_reset_req,
  input  wire logic              wdt_reset_req,
  input  wire logic              clock_fault_reset_req,
  input  wire logic              trim_reset_req,
  input  wire logic              flash_standby_reset_req,
  input  wire logic              bad_trim_detect,
  // Reset and start-up results
  output logic                   system_reset,
  output logic                   cpu_fetch_enable,
  output logic                   ext_reset_disable_effective,
  output logic                   aux_control_a_effective,
  output logic                   aux_control_b_effective,
  // Interrupt
  output logic                   irq
);

  // Register state
  logic [2:0]        pin_ctrl_reg;
  logic              ext_dis_eff_reg;
  logic              aux_a_eff_reg;
  logic              aux_b_eff_reg;
  logic [6:0]        cause_reg;
  logic              fclr_req_reg;
  logic [7:0]        irq_status_reg;
  logic [7:0]        irq_mask_reg;
  logic              irq_reg;
  logic              sys_reset_reg;
  logic              fetch_en_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic              pready_reg;
  logic              pslverr_reg;

  // Combinational helpers
  logic              internal_any;
  logic              ext_active;
  logic              reset_active;
  logic              warm_done;
  logic              setup_phase;
  logic              wr_fire;
  logic              hit_cause;
  logic              hit_pin;
  logic              hit_code;
  logic              hit_istat;
  logic              hit_imask;
  logic              hit_any;
  logic [7:0]        rd_value;

  // Per-register write strobes
  logic              wr_cause;
  logic              wr_pin;
  logic              wr_code;
  logic              wr_istat;
  logic              wr_imask;

  // Key decode and flag clearing
  logic              key_ext_dis;
  logic              key_aux;
  logic              key_flag_clr;
  logic [6:0]        cause_set;
  logic              cause_clear;
  logic              clear_by_key;
  logic [6:0]        cause_next;

  // Interrupt event and status terms
  logic [7:0]        irq_events;
  logic [7:0]        irq_status_next;

  // Source merge; external pin gated by the committed disable copy
  assign internal_any = power_on_reset_req | lvd1_reset_req | lvd2_reset_req | wdt_reset_req
                      | clock_fault_reset_req | trim_reset_req | flash_standby_reset_req;
  assign ext_active   = !ext_reset_n && !ext_dis_eff_reg;
  assign reset_active = internal_any | ext_active;

  // Registered system reset output
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_reset_reg <= 1'b1;
    end else begin
      sys_reset_reg <= reset_active;
    end
  end

  // Warm-up after each release; its length is a package constant, shorten it there for quick runs
  warmup_sequencer u_warmup (
    .ref_clk      (ref_clk),
    .sys_rst      (sys_rst),
    .reset_active (reset_active),
    .warm_done    (warm_done)
  );

  // Fetch enable follows the warm-up result
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fetch_en_reg <= 1'b0;
    end else begin
      fetch_en_reg <= warm_done && !reset_active;
    end
  end

  // APB phase decode; one-cycle access with a registered ready
  assign setup_phase = psel && !penable;
  assign wr_fire     = psel && penable && pready_reg && pwrite;

  // Address decode and read mux
  always_comb begin
    hit_cause = 1'b0;
    hit_pin   = 1'b0;
    hit_code  = 1'b0;
    hit_istat = 1'b0;
    hit_imask = 1'b0;
    rd_value  = 8'h00;
    if (paddr == reg_addr(CAUSE_IDX)) begin
      hit_cause = 1'b1;
      rd_value  = {1'b0, cause_reg};
    end else if (paddr == reg_addr(PIN_CTRL_IDX)) begin
      hit_pin  = 1'b1;
      rd_value = {5'h00, pin_ctrl_reg};
    end else if (paddr == reg_addr(CODE_IDX)) begin
      hit_code = 1'b1;
      rd_value = {5'h00, aux_b_eff_reg, aux_a_eff_reg, ext_dis_eff_reg};
    end else if (paddr == reg_addr(IRQ_STATUS_IDX)) begin
      hit_istat = 1'b1;
      rd_value  = irq_status_reg;
    end else if (paddr == reg_addr(IRQ_MASK_IDX)) begin
      hit_imask = 1'b1;
      rd_value  = irq_mask_reg;
    end
  end

  assign hit_any = hit_cause | hit_pin | hit_code | hit_istat | hit_imask;

  // Per-register write strobes, one qualified access each
  assign wr_cause = wr_fire && hit_cause;
  assign wr_pin   = wr_fire && hit_pin;
  assign wr_code  = wr_fire && hit_code;
  assign wr_istat = wr_fire && hit_istat;
  assign wr_imask = wr_fire && hit_imask;

  // Code port match; any other value commits nothing
  function automatic logic key_match(input logic [7:0] code, input logic [7:0] key);
    key_match = (code == key);
  endfunction

  // Ready and error raised for the access cycle only
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_phase;
      pslverr_reg <= setup_phase && !hit_any;
    end
  end

  // Read data captured in setup, zero on unmapped or write
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_reg <= RDATA_RST;
    end else if (setup_phase) begin
      prdata_reg <= pwrite ? RDATA_RST : {24'h000000, rd_value};
    end
  end

  // Enable code port decode; unknown codes fall through unused
  assign key_ext_dis  = wr_code && key_match(pwdata[7:0], KEY_EXT_DIS);
  assign key_aux      = wr_code && key_match(pwdata[7:0], KEY_AUX);
  assign key_flag_clr = wr_code && key_match(pwdata[7:0], KEY_FLAG_CLR);

  // Written pin control bits; any reset source wipes them
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_ctrl_reg <= PIN_CTRL_RST;
    end else if (reset_active) begin
      pin_ctrl_reg <= PIN_CTRL_RST;
    end else if (wr_pin) begin
      pin_ctrl_reg <= pwdata[2:0];
    end
  end

  // Committed disable copy survives every reset but power-on
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ext_dis_eff_reg <= 1'b0;
    end else if (power_on_reset_req) begin
      ext_dis_eff_reg <= 1'b0;
    end else if (key_ext_dis) begin
      ext_dis_eff_reg <= pin_ctrl_reg[PIN_EXT_DIS_BIT];
    end
  end

  // Committed auxiliary copies, same power-on only clearing
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aux_a_eff_reg <= 1'b0;
      aux_b_eff_reg <= 1'b0;
    end else if (power_on_reset_req) begin
      aux_a_eff_reg <= 1'b0;
      aux_b_eff_reg <= 1'b0;
    end else if (key_aux) begin
      aux_a_eff_reg <= pin_ctrl_reg[PIN_AUX_A_BIT];
      aux_b_eff_reg <= pin_ctrl_reg[PIN_AUX_B_BIT];
    end
  end

  // Clear request is a written bit, so any reset drops it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      fclr_req_reg <= 1'b0;
    end else if (reset_active || key_flag_clr) begin
      fclr_req_reg <= 1'b0;
    end else if (wr_cause) begin
      fclr_req_reg <= pwdata[CAUSE_FCLR_BIT];
    end
  end

  // Cause sets; bit 5 tracks abnormal trim detection
  always_comb begin
    cause_set                  = 7'h00;
    cause_set[CAUSE_WDT_BIT]   = wdt_reset_req;
    cause_set[CAUSE_CLK_BIT]   = clock_fault_reset_req;
    cause_set[CAUSE_LVD1_BIT]  = lvd1_reset_req;
    cause_set[CAUSE_LVD2_BIT]  = lvd2_reset_req;
    cause_set[CAUSE_TRIM_BIT]  = trim_reset_req;
    cause_set[CAUSE_TSTAT_BIT] = bad_trim_detect;
    cause_set[CAUSE_FLASH_BIT] = flash_standby_reset_req;
  end

  // Internal resets other than power-on keep flags; a new cause beats a same-cycle clear
  assign clear_by_key = key_flag_clr && fclr_req_reg;
  assign cause_clear  = power_on_reset_req || ext_active || clear_by_key;
  assign cause_next  = (cause_clear ? CAUSE_RST : cause_reg) | cause_set;

  // Reset cause flags
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cause_reg <= CAUSE_RST;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Interrupt events: new cause bits except bit 5 plus warm-up completion
  always_comb begin
    irq_events                    = {1'b0, cause_set & ~cause_reg};
    irq_events[CAUSE_TSTAT_BIT]   = 1'b0;
    irq_events[IRQ_WARM_DONE_BIT] = warm_done && !fetch_en_reg && !reset_active;
  end

  // Sticky status, write one to clear, set wins
  always_comb begin
    irq_status_next = irq_status_reg;
    if (wr_istat) begin
      irq_status_next = irq_status_reg & ~pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_status_reg <= IRQ_STAT_RST;
    end else begin
      irq_status_reg <= irq_status_next | irq_events;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_mask_reg <= IRQ_MASK_RST;
    end else if (wr_imask) begin
      irq_mask_reg <= pwdata[7:0];
    end
  end

  // Level interrupt, one cycle behind the status
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Outputs straight from flops
  assign prdata                      = prdata_reg;
  assign pready                      = pready_reg;
  assign pslverr                     = pslverr_reg;
  assign system_reset                = sys_reset_reg;
  assign cpu_fetch_enable            = fetch_en_reg;
  assign ext_reset_disable_effective = ext_dis_eff_reg;
  assign aux_control_a_effective     = aux_a_eff_reg;
  assign aux_control_b_effective     = aux_b_eff_reg;
  assign irq                         = irq_reg;

endmodule

`default_nettype wire

//--- verif/reset_source_model.sv
`timescale 1ns/100ps
`default_nettype none

module reset_source_model (
  // Clock
  input  wire logic       ref_clk,
  // Sources held active by the bench
  input  wire logic [7:0] hold,
  // Pin and internal source lines
  output logic            ext_reset_n,
  output logic [6:0]      req
);
  // Pin idles high through its pull-up, sources idle low
  initial begin
    ext_reset_n = 1'b1;
    req         = 7'h00;
  end

  // Lines change just after an edge so the block samples them cleanly
  always @(posedge ref_clk) begin
    ext_reset_n <= ~hold[0];
    req         <= hold[7:1];
  end
endmodule

`default_nettype wire

//--- verif/reset_control_checker.sv
`timescale 1ns/100ps
`default_nettype none

module reset_control_checker
  import reset_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Bus
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [DATA_W-1:0] prdata,
  input  wire logic              pready,
  // Sources
  input  wire logic              ext_reset_n,
  input  wire logic              power_on_reset_req,
  input  wire logic              lvd1_reset_req,
  input  wire logic              lvd2_reset_req,
  input  wire logic              wdt_reset_req,
  input  wire logic              clock_fault_reset_req,
  input  wire logic              trim_reset_req,
  input  wire logic              flash_standby_reset_req,
  // Results
  input  wire logic              system_reset,
  input  wire logic              cpu_fetch_enable,
  input  wire logic              ext_reset_disable_effective
);
  localparam logic [15:0] CAUSE_A = {CAUSE_IDX[13:0], 2'b00};
  localparam logic [15:0] PIN_A   = {PIN_CTRL_IDX[13:0], 2'b00};
  localparam logic [15:0] CODE_A  = {CODE_IDX[13:0], 2'b00};

  logic int_src;
  logic key_wr;
  logic rd_acc;

  // Any internal source, a disable-key write, a completed read
  assign int_src = power_on_reset_req | lvd1_reset_req | lvd2_reset_req | wdt_reset_req
                 | clock_fault_reset_req | trim_reset_req | flash_standby_reset_req;
  assign key_wr = psel & penable & pready & pwrite & (paddr == CODE_A) & (pwdata[7:0] == KEY_EXT_DIS);
  assign rd_acc = pready & ~pwrite;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_internal_forces_reset: assert property (int_src |=> system_reset)
    else $error("internal source did not reset");
  a_pin_honoured: assert property (!ext_reset_n && !ext_reset_disable_effective |=> system_reset)
    else $error("enabled pin did not reset");
  a_quiet_releases: assert property (!int_src && (ext_reset_n || ext_reset_disable_effective) |=> !system_reset)
    else $error("reset without active source");
  a_disable_held: assert property (!key_wr && !power_on_reset_req |=> $stable(ext_reset_disable_effective))
    else $error("disable copy changed without key");
  a_fetch_held: assert property (system_reset |=> !cpu_fetch_enable)
    else $error("fetch during reset");
  a_warm_restart: assert property ($fell(system_reset) |-> !cpu_fetch_enable [*8])
    else $error("fetch right after release");
  a_pin_high_zero: assert property (rd_acc && paddr == PIN_A |-> prdata[7:3] == 5'h00)
    else $error("pin control high bits set");
  a_clear_req_zero: assert property (rd_acc && paddr == CAUSE_A |-> !prdata[7])
    else $error("clear request read back");
  a_status_mirror: assert property (rd_acc && paddr == CODE_A |-> prdata[7:3] == 5'h00 && prdata[0] == ext_reset_disable_effective)
    else $error("status does not mirror copy");

  // Main scenarios
  c_key_commit: cover property (key_wr);
  c_fetch_start: cover property ($rose(cpu_fetch_enable));
  c_wdt_reset: cover property (wdt_reset_req ##1 system_reset);
endmodule

bind reset_control reset_control_checker u_chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .ext_reset_n(ext_reset_n),
  .power_on_reset_req(power_on_reset_req), .lvd1_reset_req(lvd1_reset_req), .lvd2_reset_req(lvd2_reset_req),
  .wdt_reset_req(wdt_reset_req), .clock_fault_reset_req(clock_fault_reset_req), .trim_reset_req(trim_reset_req),
  .flash_standby_reset_req(flash_standby_reset_req), .system_reset(system_reset),
  .cpu_fetch_enable(cpu_fetch_enable), .ext_reset_disable_effective(ext_reset_disable_effective)
);

`default_nettype wire

//--- verif/reset_control_tb.sv
`timescale 1ns/100ps
`default_nettype none

module reset_control_tb
  import reset_ctrl_pkg::*;
;
  logic              ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, err, bad_trim;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [7:0]        hold;
  logic [6:0]        req;
  logic              ext_n, sys_reset, fetch, eff_dis, irq, aux_a, aux_b;
  int                errors, check_count, cause_m, eff_m, pin_m, n, r;
  int                cbit[8] = '{0, 0, 2, 3, 0, 1, 4, 6};

  reset_source_model u_src (.ref_clk(ref_clk), .hold(hold), .ext_reset_n(ext_n), .req(req));

  reset_control u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_reset_n(ext_n), .power_on_reset_req(req[0]), .lvd1_reset_req(req[1]), .lvd2_reset_req(req[2]),
    .wdt_reset_req(req[3]), .clock_fault_reset_req(req[4]), .trim_reset_req(req[5]),
    .flash_standby_reset_req(req[6]), .bad_trim_detect(bad_trim), .system_reset(sys_reset),
    .cpu_fetch_enable(fetch), .ext_reset_disable_effective(eff_dis), .aux_control_a_effective(aux_a),
    .aux_control_b_effective(aux_b), .irq(irq)
  );

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic results();
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input int exp);
    check_count++;
    if (got !== exp[7:0]) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp[7:0]);
    end
  endtask

  // One APB transfer; idle cycle after so strobes never toggle twice in a step
  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= DATA_W'(d);
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (t >= 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rdchk(input logic [15:0] idx, input int exp);
    apb(1'b0, idx, 8'h00);
    chk(rd[7:0], exp);
  endtask

  // Hold one source, check reset, update model, wait out warm-up, compare registers
  task automatic src(input int b);
    bit hit;
    hit = (b != 0) || !eff_m[0];
    hold <= 8'h01 << b;
    repeat (3) @(posedge ref_clk);
    chk(sys_reset, hit);
    hold <= 8'h00;
    if (b < 2 && hit) cause_m = 0;
    if (b == 1) eff_m = 0;
    if (b > 1) cause_m |= 1 << cbit[b];
    if (hit) pin_m = 0;
    n = 0;
    while (hit && fetch !== 1'b1 && n < WARMUP_CYCLES + 50) begin
      @(posedge ref_clk);
      n++;
    end
    if (hit) chk(n >= WARMUP_CYCLES && n <= WARMUP_CYCLES + 8, 1);
    rdchk(CAUSE_IDX, cause_m);
    rdchk(PIN_CTRL_IDX, pin_m);
    rdchk(CODE_IDX, eff_m);
    chk({5'h00, aux_b, aux_a, eff_dis}, eff_m);
  endtask

  // Watchdog: whole run is well under 10 ms
  initial begin
    #10_000_000;
    errors++;
    results();
  end

  initial begin
    {psel, penable, pwrite, bad_trim, err} = 5'h00;
    paddr = '0;
    pwdata = '0;
    hold = 8'h00;
    errors = 0;
    check_count = 0;
    cause_m = 0;
    eff_m = 0;
    pin_m = 0;
    sys_rst = 1'b1;
    r = $urandom(32'hF92A);
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rdchk(CAUSE_IDX, 0);
    rdchk(PIN_CTRL_IDX, 0);
    apb(1'b0, 16'h0FD0, 8'h00);
    chk({err, rd[7:0] == 8'h00}, 3);
    // Random pin control value with disable set
    r = $urandom | 1;
    pin_m = r & 7;
    apb(1'b1, PIN_CTRL_IDX, r[7:0]);
    rdchk(PIN_CTRL_IDX, pin_m);
    rdchk(CODE_IDX, 0);
    apb(1'b1, CODE_IDX, 8'h55);
    rdchk(CODE_IDX, 0);
    apb(1'b1, CODE_IDX, KEY_AUX);
    rdchk(CODE_IDX, pin_m & 6);
    apb(1'b1, CODE_IDX, KEY_EXT_DIS);
    eff_m = pin_m;
    rdchk(CODE_IDX, eff_m);
    // Disabled pin first, then every internal source but power-on
    src(0);
    for (int b = 2; b < 8; b++) src(b);
    apb(1'b1, CODE_IDX, KEY_FLAG_CLR);
    rdchk(CAUSE_IDX, cause_m);
    bad_trim <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rdchk(CAUSE_IDX, cause_m | 32'h20);
    bad_trim <= 1'b0;
    apb(1'b1, CAUSE_IDX, 8'h80);
    apb(1'b1, CODE_IDX, KEY_FLAG_CLR);
    cause_m = 0;
    rdchk(CAUSE_IDX, 0);
    // Second watchdog reset in mid warm-up restarts the count
    hold <= 8'h10;
    repeat (3) @(posedge ref_clk);
    hold <= 8'h00;
    repeat (100) @(posedge ref_clk);
    src(4);
    // Interrupt raise, mask and clear
    apb(1'b1, IRQ_MASK_IDX, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk(irq, 1);
    apb(1'b1, IRQ_STATUS_IDX, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0);
    apb(1'b1, IRQ_MASK_IDX, 8'h00);
    // Aux copies survive a pin reset, power-on clears all
    apb(1'b1, PIN_CTRL_IDX, 8'h06);
    apb(1'b1, CODE_IDX, KEY_AUX);
    apb(1'b1, PIN_CTRL_IDX, 8'h00);
    apb(1'b1, CODE_IDX, KEY_EXT_DIS);
    eff_m = 6;
    src(0);
    src(1);
    results();
  end
endmodule

`default_nettype wire
